// ---- core/gci_pkg.sv ----
package gci_pkg;
  localparam int CLK_PERIOD_PS = 10000;
  localparam int HOLDOFF_PS = 70000;
  localparam int HOLDOFF_CYC = (HOLDOFF_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATE = 8'h04;
  localparam logic [7:0] REG_MASK = 8'h08;
  localparam logic [7:0] REG_ERR = 8'h0c;
  localparam int CTRL_HDR_BIT = 0;
  localparam logic [15:0] MASK_DEF = 16'h7f22;
  localparam logic [3:0] MENU_DEF = 4'h1;
  localparam logic [15:0] MENU_MAX = 16'h000e;
  localparam logic [2:0] PIX_PLANE1 = 3'h5;
  localparam logic [2:0] PIX_PLANE2 = 3'h6;
  localparam logic [15:0] ERR_UNKNOWN = 16'hff9c;
  localparam logic [15:0] ERR_RANGE = 16'hff2c;
  localparam logic [7:0] CH_LF = 8'h0a;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_SP = 8'h20;
  localparam logic [7:0] CH_SEMI = 8'h3b;
  localparam logic [7:0] CH_Q = 8'h3f;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_N = 8'h4e;
  // First three letters of each header; long and short forms share these three letters
  localparam logic [23:0] H_LOC = "LOC";
  localparam logic [23:0] H_LON = "LON";
  localparam logic [23:0] H_MEN = "MEN";
  localparam logic [23:0] H_MER = "MER";
  localparam logic [23:0] H_OPT = "OPT";
  localparam logic [23:0] H_PLO = "PLO";
  localparam logic [23:0] H_PRI = "PRI";
  localparam logic [23:0] H_REA = "REA";
  localparam logic [23:0] H_RDY = "RDY";
  localparam logic [23:0] H_REC = "REC";
  localparam logic [23:0] H_REM = "REM";
  localparam logic [23:0] H_REQ = "REQ";
  localparam logic [23:0] H_REQ_ALT = 24'h525153; // Three-letter alias of the mask command
  localparam logic [23:0] H_RES = "RES";
  localparam logic [23:0] H_RST = "RST";
  localparam logic [23:0] H_REV = "REV";
  localparam logic [23:0] H_RUN = "RUN";
  localparam logic [2:0] Q_LON = 3'h0;
  localparam logic [2:0] Q_MEN = 3'h1;
  localparam logic [2:0] Q_OPT = 3'h2;
  localparam logic [2:0] Q_REA = 3'h3;
  localparam logic [2:0] Q_REQ = 3'h4;
  localparam logic [2:0] Q_REV = 3'h5;

  typedef struct packed {
    logic edge_mode;
    logic [1:0] trig_src;
    logic signed [15:0] level_mv;
    logic slope_pos;
    logic sweep_auto;
    logic holdoff_time_mode;
    logic [7:0] holdoff_cyc;
    logic [7:0] holdoff_events;
    logic magnify;
    logic [15:0] win_size_mv;
    logic signed [15:0] win_pos_mv;
    logic [7:0] averages;
  } gci_settings_type;

  localparam gci_settings_type SETTINGS_DEF = '{
    edge_mode: 1'b1, trig_src: 2'h1, level_mv: 16'sh0000, slope_pos: 1'b1, sweep_auto: 1'b1,
    holdoff_time_mode: 1'b1, holdoff_cyc: 8'(HOLDOFF_CYC), holdoff_events: 8'h02, magnify: 1'b0,
    win_size_mv: 16'h1b58, win_pos_mv: 16'sh0000, averages: 8'h08};

  typedef struct packed {
    logic [63:0] txt;
    logic [2:0] last;
  } gci_hdr_type;

  function automatic gci_hdr_type hdr_text(input logic [2:0] q, input logic lng);
    gci_hdr_type h;
    h = '{txt: {"MENU", 32'h0}, last: 3'h3};
    case (q)
      Q_LON: h = lng ? '{txt: "LONGFORM", last: 3'h7} : '{txt: {"LONG", 32'h0}, last: 3'h3};
      Q_OPT: h = lng ? '{txt: {"OPTION", 16'h0}, last: 3'h5} : '{txt: {"OPT", 40'h0}, last: 3'h2};
      Q_REA: h = lng ? '{txt: {"READY", 24'h0}, last: 3'h4} : '{txt: {"READ", 32'h0}, last: 3'h3};
      Q_REQ: h = lng ? '{txt: {"REQUEST", 8'h0}, last: 3'h6} : '{txt: {"REQ", 40'h0}, last: 3'h2};
      Q_REV: h = lng ? '{txt: "REVISION", last: 3'h7} : '{txt: {"REV", 40'h0}, last: 3'h2};
      default: h = '{txt: {"MENU", 32'h0}, last: 3'h3};
    endcase
    return h;
  endfunction
endpackage

// ---- core/gci_interp.sv ----
// Implementation choices: strobed register access and the address map.
`timescale 1ns/1ps
module gci_interp #(
  parameter logic [15:0] FW_REV = 16'h1234,
  parameter logic [15:0] OPT_LIST = 16'h0000,
  parameter int ERRQ_DEPTH = 16,
  parameter int RDY_BIT = 0
) (
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Async reset, active high
  input wire logic [7:0] addr_i, // Register byte address
  input wire logic [31:0] wdata_i, // Register write data
  input wire logic wr_i, // Register write strobe
  input wire logic rd_i, // Register read strobe
  output logic [31:0] rdata_o, // Register read data
  input wire logic [7:0] rx_data_i, // Received command byte
  input wire logic rx_valid_i, // Received byte valid
  output logic rx_ready_o, // Interpreter takes bytes
  output logic [7:0] tx_data_o, // Reply byte
  output logic tx_valid_o, // Reply byte valid
  input wire logic tx_ready_i, // Talker takes reply byte
  input wire logic ren_i, // Remote enable line (pin)
  input wire logic talk_i, // Addressed to talk
  input wire logic [15:0] status_i, // Live status word
  input wire logic spoll_i, // Serial poll done pulse
  input wire logic tb_single_i, // Timebase in single mode
  output logic remote_o, // Remote state
  output logic lockout_o, // Local lockout
  output logic longform_o, // Verbose replies
  output logic [3:0] menu_o, // Selected menu
  output logic display_cmd_a_o, // Display_cmd_a pulse
  output logic [2:0] display_cmd_a_plane_o, // Target pixel memory
  output logic recall_o, // Recall pulse
  output logic [3:0] recall_reg_o, // Recall register number
  output logic dump_o, // Hardcopy start pulse
  output logic dump_raster_o, // Dump is raster (print)
  output logic arm_once_o, // Single arm pulse
  output logic run_cont_o, // Continuous run
  output logic srq_o, // Service request
  output logic [7:0] status_byte_o, // Status byte for poll
  output gci_pkg::gci_settings_type settings_o // Instrument settings
);
  import gci_pkg::*;

  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_HDR = 6'b000010,
    ST_SEP = 6'b000100,
    ST_DIG = 6'b001000,
    ST_CR = 6'b010000,
    ST_LF = 6'b100000
  } gci_state_type;

  localparam int EW = $clog2(ERRQ_DEPTH);

  function automatic logic [3:0] dec_dig(input logic [15:0] v, input logic [2:0] i);
    logic [15:0] d;
    d = 16'h0;
    case (i)
      3'h0: d = v / 16'd10000;
      3'h1: d = (v / 16'd1000) % 16'd10;
      3'h2: d = (v / 16'd100) % 16'd10;
      3'h3: d = (v / 16'd10) % 16'd10;
      default: d = v % 16'd10;
    endcase
    return d[3:0];
  endfunction

  function automatic logic [2:0] first_dig(input logic [15:0] v);
    logic [2:0] f;
    f = 3'h4;
    for (int i = 3; i >= 0; i--) begin
      if (dec_dig(v, 3'(i)) != 4'h0) begin
        f = 3'(i);
      end
    end
    return f;
  endfunction

  gci_state_type state_r, state_nxt;
  logic ren_m_r, ren_s_r;
  logic [23:0] hdr_r;
  logic [1:0] hcnt_r, acnt_r;
  logic arg_r, qry_r, hasnum_r;
  logic [15:0] num_r;
  logic [7:0] alpha2_r;
  logic hdr_en_r, rqs_on_r, plot_pend_r, print_pend_r;
  logic [15:0] mask_r, val_r;
  logic [7:0] pend_r;
  logic [2:0] qsel_r, hidx_r, didx_r;
  logic [15:0] errq [ERRQ_DEPTH];
  logic [EW:0] wp_r, rp_r;

  // Byte classes
  wire [7:0] b = rx_data_i;
  wire is_low = (b >= 8'h61) && (b <= 8'h7a);
  wire [7:0] up = is_low ? (b & 8'hdf) : b;
  wire is_alpha = (up >= 8'h41) && (up <= 8'h5a);
  wire is_dig = (b >= 8'h30) && (b <= 8'h39);
  wire is_term = (b == CH_LF) || (b == CH_SEMI);
  wire take = rx_valid_i && rx_ready_o;
  wire exec = take && is_term && (hcnt_r != 2'h0);
  wire [15:0] num10 = 16'(num_r * 16'd10 + {8'h00, b} - 16'h0030);

  // Header decode on three letters only
  wire h_loc = hdr_r == H_LOC;
  wire h_lon = hdr_r == H_LON;
  wire h_men = hdr_r == H_MEN;
  wire h_mer = hdr_r == H_MER;
  wire h_opt = hdr_r == H_OPT;
  wire h_plo = hdr_r == H_PLO;
  wire h_pri = hdr_r == H_PRI;
  wire h_rea = (hdr_r == H_REA) || (hdr_r == H_RDY);
  wire h_rec = hdr_r == H_REC;
  wire h_rem = hdr_r == H_REM;
  wire h_req = (hdr_r == H_REQ) || (hdr_r == H_REQ_ALT);
  wire h_rst = (hdr_r == H_RES) || (hdr_r == H_RST);
  wire h_rev = hdr_r == H_REV;
  wire h_run = hdr_r == H_RUN;
  wire known = h_loc | h_lon | h_men | h_mer | h_opt | h_plo | h_pri | h_rea | h_rec | h_rem | h_req
             | h_rst | h_rev | h_run;
  wire arg_on = hasnum_r ? (num_r != 16'h0) : (alpha2_r == CH_N);
  wire men_bad = h_men && !qry_r && ((num_r == 16'h0) || (num_r > MENU_MAX));
  wire mer_bad = h_mer && (num_r != 16'h1) && (num_r != 16'h2);
  wire is_reply = qry_r && (h_lon | h_men | h_opt | h_rea | h_req | h_rev);
  wire do_cmd = exec && !qry_r;
  wire mask_wr = do_cmd && h_req && hasnum_r;

  // Reply value and header select
  wire [15:0] q_val = h_lon ? {15'h0, longform_o} :
                      h_men ? {12'h0, menu_o} :
                      h_opt ? OPT_LIST :
                      h_rea ? {8'h00, status_i[15:8]} :
                      h_req ? mask_r : FW_REV;
  wire [2:0] q_sel = h_lon ? Q_LON : h_men ? Q_MEN : h_opt ? Q_OPT : h_rea ? Q_REA : h_req ? Q_REQ : Q_REV;
  wire gci_hdr_type ht = hdr_text(qsel_r, longform_o);
  wire send_adv = (state_r != ST_IDLE) && (!tx_valid_o || tx_ready_i);
  wire [7:0] hdr_byte = 8'(ht.txt >> {3'h7 - hidx_r, 3'b000});
  wire [7:0] cur_byte = (state_r == ST_HDR) ? hdr_byte :
                        (state_r == ST_SEP) ? CH_SP :
                        (state_r == ST_DIG) ? (CH_ZERO + {4'h0, dec_dig(val_r, didx_r)}) :
                        (state_r == ST_CR) ? CH_CR : CH_LF;

  // Status word: ready bit is a nonzero ready mask with all masked ready conditions true at once
  wire rdy_all = (mask_r[15:8] != 8'h00) && (&(status_i[15:8] | ~mask_r[15:8]));
  wire [7:0] rdy_pos = 8'h01 << RDY_BIT;
  wire [7:0] stb = (status_i[7:0] & ~rdy_pos) | (rdy_all ? rdy_pos : 8'h00);

  // Error queue
  wire err_push = exec && (!known || men_bad || mer_bad);
  wire [15:0] err_code = known ? ERR_RANGE : ERR_UNKNOWN;
  wire errq_empty = wp_r == rp_r;
  wire errq_full = (wp_r[EW] != rp_r[EW]) && (wp_r[EW-1:0] == rp_r[EW-1:0]);
  wire err_pop = rd_i && (addr_i == REG_ERR) && !errq_empty;

  always_comb begin
    state_nxt = state_r;
    if (state_r == ST_IDLE) begin
      if (exec && is_reply) begin
        state_nxt = hdr_en_r ? ST_HDR : ST_DIG;
      end
    end else if (send_adv) begin
      case (state_r)
        ST_HDR: state_nxt = (hidx_r == ht.last) ? ST_SEP : ST_HDR;
        ST_SEP: state_nxt = ST_DIG;
        ST_DIG: state_nxt = (didx_r == 3'h4) ? ST_CR : ST_DIG;
        ST_CR: state_nxt = ST_LF;
        default: state_nxt = ST_IDLE;
      endcase
    end
  end

  // Remote enable comes from a pin
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ren_m_r <= 1'b0;
      ren_s_r <= 1'b0;
    end else begin
      ren_m_r <= ren_i;
      ren_s_r <= ren_m_r;
    end
  end

  // Command parser
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      hdr_r <= 24'h0;
      hcnt_r <= 2'h0;
      acnt_r <= 2'h0;
      arg_r <= 1'b0;
      qry_r <= 1'b0;
      hasnum_r <= 1'b0;
      num_r <= 16'h0;
      alpha2_r <= 8'h00;
    end else if (take) begin
      if (is_term) begin
        hdr_r <= 24'h0;
        hcnt_r <= 2'h0;
        acnt_r <= 2'h0;
        arg_r <= 1'b0;
        qry_r <= 1'b0;
        hasnum_r <= 1'b0;
        num_r <= 16'h0;
        alpha2_r <= 8'h00;
      end else if (!arg_r) begin
        if (is_alpha && (hcnt_r != 2'h3)) begin
          hdr_r <= {hdr_r[15:0], up};
          hcnt_r <= hcnt_r + 2'h1;
        end else if (b == CH_Q) begin
          qry_r <= 1'b1;
        end else if ((b == CH_SP) && (hcnt_r != 2'h0)) begin
          arg_r <= 1'b1;
        end else if (is_dig && (hcnt_r != 2'h0)) begin
          arg_r <= 1'b1;
          num_r <= num10;
          hasnum_r <= 1'b1;
        end
      end else if (is_dig) begin
        num_r <= num10;
        hasnum_r <= 1'b1;
      end else if (is_alpha) begin
        if (acnt_r == 2'h1) begin
          alpha2_r <= up;
        end
        if (acnt_r != 2'h3) begin
          acnt_r <= acnt_r + 2'h1;
        end
      end
    end
  end

  // Command execution
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      remote_o <= 1'b0;
      lockout_o <= 1'b0;
      longform_o <= 1'b0;
      menu_o <= MENU_DEF;
      display_cmd_a_o <= 1'b0;
      display_cmd_a_plane_o <= PIX_PLANE1;
      recall_o <= 1'b0;
      recall_reg_o <= 4'h0;
      arm_once_o <= 1'b0;
      run_cont_o <= 1'b0;
      plot_pend_r <= 1'b0;
      print_pend_r <= 1'b0;
      mask_r <= MASK_DEF;
      rqs_on_r <= 1'b0;
      settings_o <= SETTINGS_DEF;
    end else begin
      display_cmd_a_o <= 1'b0;
      recall_o <= 1'b0;
      arm_once_o <= 1'b0;
      if (!ren_s_r) begin
        remote_o <= 1'b0;
        lockout_o <= 1'b0;
      end
      if (do_cmd) begin
        if (h_loc) begin
          remote_o <= 1'b0;
          lockout_o <= 1'b0;
        end
        if (h_lon) begin
          longform_o <= arg_on;
        end
        if (h_men && !men_bad) begin
          menu_o <= num_r[3:0];
        end
        if (h_mer && !mer_bad) begin
          display_cmd_a_o <= 1'b1;
          display_cmd_a_plane_o <= (num_r == 16'h1) ? PIX_PLANE1 : PIX_PLANE2;
        end
        if (h_plo) begin
          plot_pend_r <= 1'b1;
        end
        if (h_pri) begin
          print_pend_r <= 1'b1;
        end
        if (h_rec) begin
          recall_o <= 1'b1;
          recall_reg_o <= num_r[3:0];
        end
        if (h_rem && ren_s_r) begin
          remote_o <= 1'b1;
          lockout_o <= 1'b1;
        end
        if (h_req) begin
          if (hasnum_r) begin
            mask_r <= num_r;
          end else begin
            rqs_on_r <= arg_on;
          end
        end
        if (h_rst) begin
          longform_o <= 1'b0;
          menu_o <= MENU_DEF;
          run_cont_o <= 1'b0;
          mask_r <= MASK_DEF;
          rqs_on_r <= 1'b0;
          settings_o <= SETTINGS_DEF;
        end
        if (h_run) begin
          if (tb_single_i) begin
            arm_once_o <= 1'b1;
          end else begin
            run_cont_o <= 1'b1;
          end
        end
      end
      // Dump waits for talk addressing; controller must not program meanwhile
      if (talk_i && (plot_pend_r || print_pend_r)) begin
        plot_pend_r <= 1'b0;
        print_pend_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      dump_o <= 1'b0;
      dump_raster_o <= 1'b0;
    end else begin
      dump_o <= talk_i && (plot_pend_r || print_pend_r);
      if (talk_i && (plot_pend_r || print_pend_r)) begin
        dump_raster_o <= print_pend_r && !plot_pend_r;
      end
    end
  end

  // Service request: pending bits latch, new events win over a clear
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pend_r <= 8'h00;
      srq_o <= 1'b0;
      status_byte_o <= 8'h00;
    end else begin
      pend_r <= ((mask_wr || spoll_i || (do_cmd && h_rst)) ? 8'h00 : pend_r) | (stb & mask_r[7:0]);
      srq_o <= rqs_on_r && (pend_r != 8'h00);
      status_byte_o <= stb;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wp_r <= '0;
      rp_r <= '0;
    end else if (mask_wr || (do_cmd && h_rst)) begin
      rp_r <= wp_r;
    end else begin
      if (err_push && !errq_full) begin
        wp_r <= wp_r + 1'b1;
      end
      if (err_pop) begin
        rp_r <= rp_r + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (err_push && !errq_full) begin
      errq[wp_r[EW-1:0]] <= err_code;
    end
  end

  // Reply sender
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= ST_IDLE;
      rx_ready_o <= 1'b0;
      tx_data_o <= 8'h00;
      tx_valid_o <= 1'b0;
      val_r <= 16'h0;
      qsel_r <= Q_LON;
      hidx_r <= 3'h0;
      didx_r <= 3'h0;
    end else begin
      state_r <= state_nxt;
      rx_ready_o <= state_nxt == ST_IDLE;
      if ((state_r == ST_IDLE) && exec && is_reply) begin
        val_r <= q_val;
        qsel_r <= q_sel;
        hidx_r <= 3'h0;
        didx_r <= first_dig(q_val);
      end
      if (send_adv) begin
        tx_data_o <= cur_byte;
        tx_valid_o <= 1'b1;
        if (state_r == ST_HDR) begin
          hidx_r <= hidx_r + 3'h1;
        end
        if (state_r == ST_DIG) begin
          didx_r <= didx_r + 3'h1;
        end
      end else if (tx_ready_i) begin
        tx_valid_o <= 1'b0;
      end
    end
  end

  // Register port
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      hdr_en_r <= 1'b0;
      rdata_o <= 32'h0;
    end else begin
      if (wr_i && (addr_i == REG_CTRL)) begin
        hdr_en_r <= wdata_i[CTRL_HDR_BIT];
      end
      if (!rd_i) begin
        rdata_o <= 32'h0;
      end else if (addr_i == REG_CTRL) begin
        rdata_o <= {31'h0, hdr_en_r};
      end else if (addr_i == REG_STATE) begin
        rdata_o <= {16'h0, 2'h0, 5'(wp_r - rp_r), srq_o, rqs_on_r, menu_o, longform_o, lockout_o, remote_o};
      end else if (addr_i == REG_MASK) begin
        rdata_o <= {16'h0, mask_r};
      end else if (addr_i == REG_ERR) begin
        rdata_o <= errq_empty ? 32'h0 : {16'h0, errq[rp_r[EW-1:0]]};
      end else begin
        rdata_o <= 32'h0;
      end
    end
  end
endmodule

// ---- sim/gci_props.sv ----
`timescale 1ns/1ps
module gci_props
  import gci_pkg::*;
(
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic tx_ready_i, // Reply taken
  input wire logic talk_i, // Addressed to talk
  input wire logic ren_i, // Remote enable
  input wire logic tb_single_i, // Single timebase
  input wire logic [7:0] tx_data_o, // Reply byte
  input wire logic tx_valid_o, // Reply valid
  input wire logic remote_o, // Remote state
  input wire logic lockout_o, // Lockout
  input wire logic [3:0] menu_o, // Menu
  input wire logic display_cmd_a_o, // Display_cmd_a pulse
  input wire logic [2:0] display_cmd_a_plane_o, // Display_cmd_a target
  input wire logic dump_o, // Dump pulse
  input wire logic arm_once_o, // Single arm
  input wire gci_settings_type settings_o // Settings
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  menu_range_a: assert property (menu_o >= 4'h1 && menu_o <= 4'he)
    else $error("menu out of range");
  display_cmd_a_plane_a: assert property (display_cmd_a_o |-> display_cmd_a_plane_o == PIX_PLANE1 || display_cmd_a_plane_o == PIX_PLANE2)
    else $error("display_cmd_a target not a pixel plane");
  display_cmd_a_pulse_a: assert property (display_cmd_a_o |=> !display_cmd_a_o)
    else $error("display_cmd_a pulse too long");
  dump_talk_a: assert property (dump_o |-> $past(talk_i))
    else $error("dump without talk");
  reply_hold_a: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
    else $error("reply byte dropped");
  reset_defaults_a: assert property ($fell(rst_i) |-> settings_o == SETTINGS_DEF && menu_o == MENU_DEF)
    else $error("defaults missing after reset");
  lockout_remote_a: assert property (lockout_o |-> remote_o)
    else $error("lockout outside remote");
  remote_ren_a: assert property ($rose(remote_o) |-> $past(ren_i, 3))
    else $error("remote without enable");
  arm_single_a: assert property (arm_once_o |-> $past(tb_single_i))
    else $error("single arm outside single mode");
endmodule

// ---- sim/gci_host.sv ----
`timescale 1ns/1ps
module gci_host (
  input wire logic clk_i, // Clock
  output logic [7:0] rx_data_o, // Command byte
  output logic rx_valid_o, // Byte offered
  input wire logic rx_ready_i, // Bytes taken
  input wire logic [7:0] tx_data_i, // Reply byte
  input wire logic tx_valid_i, // Reply valid
  output logic tx_ready_o // Reply taken
);
  logic slow = 1'b0;
  logic [127:0] rep = '0;
  int nb = 0;
  int nlf = 0;
  initial begin
    rx_data_o = 8'h00;
    rx_valid_o = 1'b0;
    tx_ready_o = 1'b1;
  end
  // Slow mode is ready for a reply byte on every other cycle
  always @(posedge clk_i) begin
    tx_ready_o <= slow ? !tx_ready_o : 1'b1;
    if (tx_valid_i && tx_ready_o) begin
      rep <= {rep[119:0], tx_data_i};
      nb <= nb + 1;
      if (tx_data_i == 8'h0a)
        nlf <= nlf + 1;
    end
  end
  task automatic xfer(input string s, output logic [127:0] r, output bit ok);
    string t;
    int b0;
    int n0;
    bit rdy;
    bit qry;
    t = {s, "\n"};
    b0 = nb;
    n0 = nlf;
    ok = 1'b0;
    qry = 1'b0;
    r = '0;
    @(posedge clk_i);
    for (int i = 0; i < t.len(); i++) begin
      rx_data_o <= t[i];
      rx_valid_o <= 1'b1;
      if (t[i] == "?")
        qry = 1'b1;
      rdy = 1'b0;
      for (int k = 0; k < 100 && !rdy; k++) begin
        @(negedge clk_i) rdy = rx_ready_i;
        @(posedge clk_i);
      end
      if (!rdy)
        return;
    end
    rx_valid_o <= 1'b0;
    rx_data_o <= ~t[t.len() - 1];
    // Nothing more goes out until the reply has ended
    for (int k = 0; k < 200 && qry && nlf == n0; k++) @(posedge clk_i);
    repeat (3) @(posedge clk_i);
    if (qry && nlf == n0)
      return;
    r = rep & ((128'h1 << (8 * (nb - b0))) - 128'h1);
    ok = 1'b1;
  endtask
endmodule

// ---- sim/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  import gci_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, ren_i = 1'b0, talk_i = 1'b0, tb_single_i = 1'b0;
  logic [7:0] addr_i = 8'h00, rx_data_i, tx_data_o, status_byte_o;
  logic [31:0] wdata_i = '0, rdata_o;
  logic [15:0] status_i = '0;
  logic rx_valid_i, rx_ready_o, tx_valid_o, tx_ready_i, remote_o, lockout_o, longform_o, display_cmd_a_o, recall_o;
  logic dump_o, dump_raster_o, arm_once_o, run_cont_o, srq_o, spoll_i = 1'b0;
  logic [3:0] menu_o, recall_reg_o, rreg = 4'h0;
  logic [2:0] display_cmd_a_plane_o, mplane = 3'h0;
  gci_settings_type settings_o;
  int bad_count = 0, checks = 0, ndump = 0, narm = 0;

  gci_interp #(.FW_REV(16'h1234)) u_gci_interp (.clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .rx_data_i, .rx_valid_i, .rx_ready_o, .tx_data_o, .tx_valid_o, .tx_ready_i, .ren_i, .talk_i, .status_i,
    .spoll_i, .tb_single_i, .remote_o, .lockout_o, .longform_o, .menu_o, .display_cmd_a_o, .display_cmd_a_plane_o,
    .recall_o, .recall_reg_o, .dump_o, .dump_raster_o, .arm_once_o, .run_cont_o, .srq_o, .status_byte_o,
    .settings_o);
  gci_host u_gci_host (.clk_i, .rx_data_o(rx_data_i), .rx_valid_o(rx_valid_i), .rx_ready_i(rx_ready_o),
    .tx_data_i(tx_data_o), .tx_valid_i(tx_valid_o), .tx_ready_o(tx_ready_i));

  initial forever #5 clk_i = ~clk_i;

  // Pulse outputs are latched so scenarios can look at them later
  always @(posedge clk_i) begin
    if (display_cmd_a_o) mplane <= display_cmd_a_plane_o;
    if (recall_o) rreg <= recall_reg_o;
    if (dump_o) ndump <= ndump + 1;
    if (arm_once_o) narm <= narm + 1;
  end

  task automatic give_verdict;
    if (bad_count == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [127:0] seen, input logic [127:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %0h, seen %0h", nm, exp, seen);
    end
  endtask
  task automatic q(input string s, input logic [127:0] e);
    logic [127:0] r;
    bit ok;
    u_gci_host.xfer(s, r, ok);
    if (!ok) begin
      bad_count++;
      give_verdict;
    end else if (e !== '0) begin
      chk(s, r, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    chk("register", rdata_o, e);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  initial begin
    tick(4);
    rst_i <= 1'b0;
    tick(2);
    chk("settings", settings_o, SETTINGS_DEF);
    rdc(REG_MASK, {16'h0, MASK_DEF});
    rdc(8'h10, '0);
    q("MENU 14", '0);
    chk("menu", menu_o, 4'he);
    q("MENU?", "14\r\n");
    q("MENU 15", '0);
    chk("menu", menu_o, 4'he);
    rdc(REG_ERR, {16'h0, ERR_RANGE});
    q("XYZ", '0);
    rdc(REG_ERR, {16'h0, ERR_UNKNOWN});
    rdc(REG_ERR, '0);
    wr(REG_CTRL, 32'h1);
    q("OPT?", "OPT 0\r\n");
    q("LONGFORM 1", '0);
    chk("longform", longform_o, 1'b1);
    rdc(REG_STATE, 32'h74);
    q("OPTION?", "OPTION 0\r\n");
    u_gci_host.slow = 1'b1;
    q("LONG?", "LONGFORM 1\r\n");
    u_gci_host.slow = 1'b0;
    q("LONG 0", '0);
    q("LON?", "LONG 0\r\n");
    wr(REG_CTRL, 32'h0);
    q("REV?", "4660\r\n");
    q("MER PLANE2", '0);
    chk("plane", mplane, PIX_PLANE2);
    q("MERG PLANE1", '0);
    chk("plane", mplane, PIX_PLANE1);
    q("REMOTE", '0);
    chk("remote", remote_o, 1'b0);
    ren_i <= 1'b1;
    tick(4);
    q("REMOTE", '0);
    chk("lock", {remote_o, lockout_o}, 2'h3);
    q("LOCAL", '0);
    chk("lock", {remote_o, lockout_o}, 2'h0);
    q("REC 3", '0);
    chk("recall", rreg, 4'h3);
    q("PLOT", '0);
    chk("dumps", ndump, 0);
    talk_i <= 1'b1;
    tick(3);
    talk_i <= 1'b0;
    chk("plot", {ndump[1:0], dump_raster_o}, 3'h2);
    q("PRINT", '0);
    talk_i <= 1'b1;
    tick(3);
    talk_i <= 1'b0;
    chk("print", {ndump[1:0], dump_raster_o}, 3'h5);
    tb_single_i <= 1'b1;
    q("RUN", '0);
    chk("single", {narm[1:0], run_cont_o}, 3'h2);
    tb_single_i <= 1'b0;
    q("RUN", '0);
    chk("cont", {narm[1:0], run_cont_o}, 3'h3);
    q("REQUEST 258", '0);
    q("REQ?", "258\r\n");
    status_i <= 16'h0100;
    tick(3);
    chk("ready bit", status_byte_o[0], 1'b1);
    q("RDY?", "1\r\n");
    q("REQ OFF", '0);
    status_i <= 16'h0102;
    tick(3);
    chk("status byte", status_byte_o[1], 1'b1);
    status_i <= 16'h0100;
    tick(3);
    chk("srq", srq_o, 1'b0);
    q("REQ ON", '0);
    chk("srq", srq_o, 1'b1);
    spoll_i <= 1'b1;
    tick(1);
    spoll_i <= 1'b0;
    tick(3);
    chk("srq", srq_o, 1'b0);
    status_i <= 16'h0102;
    tick(1);
    status_i <= 16'h0100;
    tick(3);
    chk("srq", srq_o, 1'b1);
    q("REQUEST 258", '0);
    chk("srq", srq_o, 1'b0);
    q("MENU 3", '0);
    q("RESET", '0);
    chk("menu", menu_o, MENU_DEF);
    chk("settings", settings_o, SETTINGS_DEF);
    give_verdict;
  end
endmodule

bind gci_interp gci_props u_gci_props (.clk_i, .rst_i, .tx_ready_i, .talk_i, .ren_i, .tb_single_i, .tx_data_o,
  .tx_valid_o, .remote_o, .lockout_o, .menu_o, .display_cmd_a_o, .display_cmd_a_plane_o, .dump_o, .arm_once_o, .settings_o);
